// File: shared/sipd_pkg.sv
// constants and carriers for the stop/idle power-down controller
package sipd_pkg;
    localparam logic [7:0] STOP_OPCODE = 8'h7F;
    localparam logic [7:0] IDLE_OPCODE = 8'h6F;
    localparam logic [7:0] STOP_ENABLE_PATTERN = 8'hA5;
    localparam logic [7:0] STOP_CTRL_RESET = 8'h00;
    localparam logic [1:0] DIV_SELECT_RESET = 2'h0;
    localparam logic [15:0] RESET_START_ADDR = 16'h0100;
    localparam int unsigned CLK_HZ = 20000000;
    // default stabilization wait, in microseconds
    localparam int unsigned STAB_DEFAULT_US = 100;
    localparam int unsigned STAB_DEFAULT_CYC =
        (CLK_HZ / 1000000) * STAB_DEFAULT_US;
    localparam int unsigned STAB_WIDTH = 16;
    localparam int unsigned FILTER_LEN = 4;
    localparam int unsigned EXT_INT_COUNT = 12;

    typedef enum logic [2:0] {
        SIPD_RUN,
        SIPD_IDLE,
        SIPD_STOP,
        SIPD_WAKE_WAIT,
        SIPD_RESET_WAIT
    } sipd_state_e;

    // cpu side request group
    typedef struct packed {
        logic opValid;
        logic [7:0] opcode;
        logic [15:0] nextPc;
    } sipd_cpu_req_s;

    // wake answer towards the cpu
    typedef struct packed {
        logic fetchStart;
        logic [15:0] fetchAddr;
        logic serviceIrq;
    } sipd_cpu_ans_s;

    // whole controller state
    typedef struct packed {
        sipd_state_e state;
        logic [STAB_WIDTH-1:0] stabCnt;
        logic [7:0] stopCtrl;
        logic [1:0] divSelect;
        logic [15:0] resumePc;
        logic fromReset;
        logic oscEnable;
        logic cpuClkEnable;
        logic periphClkEnable;
        logic portDirHold;
        sipd_cpu_ans_s ans;
    } sipd_ctrl_s;
endpackage : sipd_pkg

// File: core/sipd_int_filter.sv
// noise filter and synchroniser for the external wake interrupts
`timescale 1ns/1ps
`default_nettype none
module sipd_int_filter (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // raw pins and filtered levels
    input wire logic [sipd_pkg::EXT_INT_COUNT-1:0] pinRaw,
    output logic [sipd_pkg::EXT_INT_COUNT-1:0] pinClean
);
    // one sync-and-filter chain per pin
    genvar i;
    generate
        for (i = 0; i < sipd_pkg::EXT_INT_COUNT; i++)
        begin : g_pin
            logic meta_reg;
            logic sync_reg;
            logic [sipd_pkg::FILTER_LEN-1:0] hist_reg;
            logic clean_reg;
            // a pulse shorter than the filter length is ignored
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    hist_reg <= '0;
                    clean_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= pinRaw[i];
                    sync_reg <= meta_reg;
                    hist_reg <= {hist_reg[sipd_pkg::FILTER_LEN-2:0],
                        sync_reg};
                    if (&hist_reg)
                        clean_reg <= 1'b1;
                    else if (~|hist_reg)
                        clean_reg <= 1'b0;
                end
            end
            assign pinClean[i] = clean_reg;
        end
    endgenerate
endmodule : sipd_int_filter
`default_nettype wire

// File: core/sipd_power_ctrl.sv
// stop and idle power-down sequencer
`timescale 1ns/1ps
`default_nettype none
module sipd_power_ctrl (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // cpu instruction report
    input wire sipd_pkg::sipd_cpu_req_s cpuReq,
    // software writes to stop control and divider select
    input wire logic stopCtrlWrite,
    input wire logic [7:0] stopCtrlData,
    input wire logic divSelectWrite,
    input wire logic [1:0] divSelectData,
    input wire logic [sipd_pkg::STAB_WIDTH-1:0] stabCount,
    // interrupt sources
    input wire logic [sipd_pkg::EXT_INT_COUNT-1:0] extIntPin,
    input wire logic [sipd_pkg::EXT_INT_COUNT-1:0] extIntEnable,
    input wire logic internalIrq,
    // clock gating and status
    output logic oscEnable,
    output logic cpuClkEnable,
    output logic periphClkEnable,
    output logic portDirHold,
    output logic [1:0] divSelect,
    output logic [7:0] stopCtrl,
    output logic [15:0] resumePc,
    // answer to the cpu
    output sipd_pkg::sipd_cpu_ans_s cpuAns
);
    // notes on the sequencer for whoever picks it up next
    // the core clock stands for the oscillator. stop shows as a low
    //   oscEnable; the simulation clock runs on so that the wake filter
    //   and counters go on working, but neither the cpu nor the
    //   peripherals may use a cycle while oscEnable is low.
    // stop is honoured only while the stop control register holds the
    //   enable pattern as the opcode retires, so a runaway program that
    //   hits the stop opcode cannot freeze the part by accident.
    // idle is always honoured. only the cpu clock is gated, so timers
    //   and serial blocks keep working and may raise the waking interrupt.
    // opcodes reported outside the run state are dropped: a gated cpu
    //   retires nothing, and whatever shows up is a glitch on its bus.
    // a stop wake comes only from the twelve external pins, after the
    //   synchroniser and the noise filter, and only while enabled; the
    //   internal sources have no clock to raise anything with.
    // an idle wake comes from any enabled source. with every source
    //   masked the reset pin is the only way out.
    // no wake touches the divider select bits. only a reset clears them,
    //   which drops the system clock to its slowest setting.
    // both a stop wake and a reset release count a stabilization wait
    //   before the cpu clock returns. the stop wake loads the count on stabCount
    //   in the cycle the wake is seen; a reset uses the package default.
    // the answer pulses last one cycle. fetchStart carries the reset
    //   start address; serviceIrq tells the cpu to take the waking
    //   interrupt and, on return, go on from the address in resumePc.
    // resumePc is caught on entry to either mode and means something only
    //   after an interrupt wake; after a reset it reads zero.
    // a write to the stop control register in the cycle of a stop wake
    //   loses, as the wake clears the register: one arming, one stop.
    // the port direction hold stays high for the whole idle stay and
    //   drops with the return of the cpu clock.
    // reset is asynchronous and loads constants only; the sequencer
    //   leaves it in the reset wait with the oscillator already running.
    // there is no buffering: an opcode report while a mode is being
    //   entered or left is simply not looked at.

    sipd_pkg::sipd_ctrl_s ctrl_reg;
    sipd_pkg::sipd_ctrl_s ctrl_next;
    logic [sipd_pkg::EXT_INT_COUNT-1:0] extClean;
    logic extWake;
    logic anyWake;
    logic stopReq;
    logic idleReq;

    // pins are synchronised and filtered before any logic sees them
    sipd_int_filter i_sipd_int_filter (
        .core_clk(core_clk),
        .rst(rst),
        .pinRaw(extIntPin),
        .pinClean(extClean)
    );

    // only enabled filtered pins may wake from stop
    assign extWake = |(extClean & extIntEnable);
    // idle wakes on any enabled interrupt; all masked means stay
    assign anyWake = extWake | internalIrq;

    // opcode decode. only the run state listens, as a gated cpu cannot
    // retire anything; a stop opcode without the enable pattern already
    // in the stop control register is dropped, which keeps a stray
    // opcode from freezing the part
    assign stopReq = cpuReq.opValid &&
        cpuReq.opcode == sipd_pkg::STOP_OPCODE &&
        ctrl_reg.stopCtrl == sipd_pkg::STOP_ENABLE_PATTERN;
    assign idleReq = cpuReq.opValid &&
        cpuReq.opcode == sipd_pkg::IDLE_OPCODE;

    // next-state logic
    always_comb
    begin
        ctrl_next = ctrl_reg;
        ctrl_next.ans.fetchStart = 1'b0;
        ctrl_next.ans.serviceIrq = 1'b0;
        if (stopCtrlWrite)
            ctrl_next.stopCtrl = stopCtrlData;
        if (divSelectWrite)
            ctrl_next.divSelect = divSelectData;
        unique case (ctrl_reg.state)
            sipd_pkg::SIPD_RUN:
            begin
                // the return address is caught here; the cpu bus is
                // quiet for the whole of the stay
                if (stopReq)
                begin
                    // halt oscillator, cpu and peripherals
                    ctrl_next.state = sipd_pkg::SIPD_STOP;
                    ctrl_next.oscEnable = 1'b0;
                    ctrl_next.cpuClkEnable = 1'b0;
                    ctrl_next.periphClkEnable = 1'b0;
                    ctrl_next.resumePc = cpuReq.nextPc;
                end
                else if (idleReq)
                begin
                    // cpu clock gated, peripherals keep running
                    ctrl_next.state = sipd_pkg::SIPD_IDLE;
                    ctrl_next.cpuClkEnable = 1'b0;
                    ctrl_next.portDirHold = 1'b1;
                    ctrl_next.resumePc = cpuReq.nextPc;
                end
            end
            sipd_pkg::SIPD_IDLE:
            begin
                // with every source masked only the reset pin ends
                // the stay, as nothing else can raise anyWake
                // divider select left as is on interrupt release
                if (anyWake)
                begin
                    ctrl_next.state = sipd_pkg::SIPD_RUN;
                    ctrl_next.cpuClkEnable = 1'b1;
                    ctrl_next.portDirHold = 1'b0;
                    ctrl_next.ans.serviceIrq = 1'b1;
                end
            end
            sipd_pkg::SIPD_STOP:
            begin
                // the enable is applied after the filter, so a masked
                // pin may toggle freely without waking the part
                // only the clean external pins can restart the clock
                if (extWake)
                begin
                    ctrl_next.state = sipd_pkg::SIPD_WAKE_WAIT;
                    ctrl_next.oscEnable = 1'b1;
                    ctrl_next.stabCnt = stabCount;
                    ctrl_next.stopCtrl = sipd_pkg::STOP_CTRL_RESET;
                end
            end
            sipd_pkg::SIPD_WAKE_WAIT,
            sipd_pkg::SIPD_RESET_WAIT:
            begin
                // one count per cycle; a zero count still costs a cycle
                if (ctrl_reg.stabCnt != '0)
                    ctrl_next.stabCnt = ctrl_reg.stabCnt - 1'b1;
                else
                begin
                    // clocks come back and the cpu learns why it woke
                    ctrl_next.state = sipd_pkg::SIPD_RUN;
                    ctrl_next.cpuClkEnable = 1'b1;
                    ctrl_next.periphClkEnable = 1'b1;
                    ctrl_next.fromReset = 1'b0;
                    if (ctrl_reg.fromReset)
                    begin
                        ctrl_next.ans.fetchStart = 1'b1;
                        ctrl_next.ans.fetchAddr =
                            sipd_pkg::RESET_START_ADDR;
                    end
                    else
                        ctrl_next.ans.serviceIrq = 1'b1;
                end
            end
            // an illegal code can only come from an upset; run is the exit
            default:
                ctrl_next.state = sipd_pkg::SIPD_RUN;
        endcase
    end

    // reset loads defaults; oscillator stays up while counting out
    // resumePc and the answer fields mean nothing until first used,
    // but they are cleared anyway so no unknown leaves the block
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg.state <= sipd_pkg::SIPD_RESET_WAIT;
            ctrl_reg.stabCnt <=
                sipd_pkg::STAB_WIDTH'(sipd_pkg::STAB_DEFAULT_CYC);
            ctrl_reg.stopCtrl <= sipd_pkg::STOP_CTRL_RESET;
            ctrl_reg.divSelect <= sipd_pkg::DIV_SELECT_RESET;
            ctrl_reg.resumePc <= 16'h0000;
            ctrl_reg.fromReset <= 1'b1;
            ctrl_reg.oscEnable <= 1'b1;
            ctrl_reg.cpuClkEnable <= 1'b0;
            ctrl_reg.periphClkEnable <= 1'b0;
            ctrl_reg.portDirHold <= 1'b0;
            ctrl_reg.ans.fetchStart <= 1'b0;
            ctrl_reg.ans.fetchAddr <= 16'h0000;
            ctrl_reg.ans.serviceIrq <= 1'b0;
        end
        else
            ctrl_reg <= ctrl_next;
    end

    // outputs straight from the state register
    // all are flops, so no decode glitch can reach a clock gate; the
    // price is one cycle of latency on every mode change
    assign oscEnable = ctrl_reg.oscEnable;
    assign cpuClkEnable = ctrl_reg.cpuClkEnable;
    assign periphClkEnable = ctrl_reg.periphClkEnable;
    assign portDirHold = ctrl_reg.portDirHold;
    assign divSelect = ctrl_reg.divSelect;
    assign stopCtrl = ctrl_reg.stopCtrl;
    assign resumePc = ctrl_reg.resumePc;
    assign cpuAns = ctrl_reg.ans;
endmodule : sipd_power_ctrl
`default_nettype wire

// File: bench/sipd_power_props.sv
// port assertions for the power-down sequencer
`timescale 1ns/1ps
`default_nettype none
module sipd_power_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // watched inputs
    input wire sipd_pkg::sipd_cpu_req_s cpuReq,
    input wire logic divSelectWrite,
    input wire logic [sipd_pkg::STAB_WIDTH-1:0] stabCount,
    input wire logic [sipd_pkg::EXT_INT_COUNT-1:0] extIntEnable,
    input wire logic internalIrq,
    // watched outputs
    input wire logic oscEnable,
    input wire logic cpuClkEnable,
    input wire logic periphClkEnable,
    input wire logic portDirHold,
    input wire logic [1:0] divSelect,
    input wire logic [7:0] stopCtrl,
    input wire sipd_pkg::sipd_cpu_ans_s cpuAns
);
    logic [15:0] relCnt;
    logic [15:0] wakeCnt;
    logic wasStop;
    logic isIdle;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // idle is the only state with cpu gated and peripherals clocked
    assign isIdle = !cpuClkEnable && periphClkEnable;
    // edges since reset release and since the oscillator came back
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            relCnt <= 16'h0000;
            wakeCnt <= 16'h0000;
            wasStop <= 1'b0;
        end
        else
        begin
            relCnt <= (relCnt == 16'hFFFF) ? relCnt : relCnt + 16'h0001;
            wakeCnt <= oscEnable ? wakeCnt + 16'h0001 : 16'h0000;
            wasStop <= !oscEnable || (wasStop && !cpuClkEnable);
        end
    end
    sequence sStopOp;
        cpuClkEnable && cpuReq.opValid && cpuReq.opcode == 8'h7F &&
            stopCtrl == sipd_pkg::STOP_ENABLE_PATTERN;
    endsequence
    sequence sIdleOp;
        cpuClkEnable && cpuReq.opValid && cpuReq.opcode == 8'h6F;
    endsequence
    sequence sWakeDone;
        $rose(cpuClkEnable) && wasStop;
    endsequence
    AST_STOP_ENTRY:
        assert property (sStopOp |=> !oscEnable && !cpuClkEnable)
        else $error("stop opcode did not halt the clocks");
    AST_IDLE_ENTRY:
        assert property (sIdleOp |=> isIdle && oscEnable && portDirHold)
        else $error("idle opcode did not gate only the cpu");
    AST_DIV_KEPT:
        assert property (!divSelectWrite |=> $stable(divSelect))
        else $error("divider select changed without a write");
    AST_RESET_VALUES:
        assert property ($fell(rst) |-> divSelect == 2'h0 &&
            stopCtrl == 8'h00 && oscEnable && !cpuClkEnable)
        else $error("controls not at defaults after reset");
    AST_RESET_FETCH:
        assert property (cpuAns.fetchStart |-> cpuAns.fetchAddr == 16'h0100
            && relCnt >= 16'h07CF && relCnt <= 16'h07D5)
        else $error("reset fetch at wrong time or address");
    AST_STOP_CLEAR:
        assert property ($rose(oscEnable) |-> stopCtrl == 8'h00 &&
            !cpuClkEnable)
        else $error("stop wake left stop control set");
    AST_STAB_WAIT:
        assert property (sWakeDone |-> wakeCnt + 16'h0001 >= stabCount &&
            wakeCnt <= stabCount + 16'h0002)
        else $error("stop wake ignored the stabilization count");
    AST_IDLE_HOLD:
        assert property (isIdle && !internalIrq && !$past(internalIrq) &&
            extIntEnable == '0 && $past(extIntEnable) == '0 |=> isIdle)
        else $error("idle left with no wake source");
    AST_IDLE_WAKE:
        assert property (isIdle && internalIrq |-> ##[0:2] cpuAns.serviceIrq)
        else $error("enabled interrupt did not end idle");
endmodule : sipd_power_props
bind sipd_power_ctrl sipd_power_props i_sipd_power_props (.core_clk(core_clk),
    .rst(rst), .cpuReq(cpuReq), .divSelectWrite(divSelectWrite),
    .stabCount(stabCount), .extIntEnable(extIntEnable),
    .internalIrq(internalIrq), .oscEnable(oscEnable),
    .cpuClkEnable(cpuClkEnable), .periphClkEnable(periphClkEnable),
    .portDirHold(portDirHold), .divSelect(divSelect), .stopCtrl(stopCtrl),
    .cpuAns(cpuAns));
`default_nettype wire

// File: bench/sipd_cpu_model.sv
// behavioural cpu core that retires power-down opcodes
`timescale 1ns/1ps
`default_nettype none
module sipd_cpu_model (
    // clock and cpu clock gate
    input wire logic core_clk,
    input wire logic cpuClkEnable,
    // opcode report and stop control writes
    output sipd_pkg::sipd_cpu_req_s cpuReq,
    output logic stopCtrlWrite,
    output logic [7:0] stopCtrlData
);
    // runs from the internal oscillator only
    initial
    begin
        cpuReq = '0;
        stopCtrlWrite = 1'b0;
        stopCtrlData = 8'h00;
    end
    // single-cycle stop control write
    task automatic put(input logic [7:0] data);
        @(posedge core_clk);
        stopCtrlWrite <= 1'b1;
        stopCtrlData <= data;
        @(posedge core_clk);
        stopCtrlWrite <= 1'b0;
    endtask : put
    // a halted cpu retires nothing, so wait for its clock first
    task automatic run(input logic [7:0] op, input logic [15:0] pc,
        input logic arm);
        while (cpuClkEnable !== 1'b1)
            @(posedge core_clk);
        if (arm)
            put(sipd_pkg::STOP_ENABLE_PATTERN);
        @(posedge core_clk);
        cpuReq <= '{1'b1, op, pc};
        @(posedge core_clk);
        cpuReq.opValid <= 1'b0;
    endtask : run
endmodule : sipd_cpu_model
`default_nettype wire

// File: bench/sipd_power_ctrl_test.sv
// self-checking bench for the power-down sequencer
`timescale 1ns/1ps
`default_nettype none
module sipd_power_ctrl_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic divSelectWrite = 1'b0;
    logic [1:0] divSelectData = 2'h0;
    logic [15:0] stabCount = 16'h0014;
    logic [11:0] extIntPin = 12'h000;
    logic [11:0] extIntEnable = 12'hFFF;
    logic internalIrq = 1'b0;
    logic stopCtrlWrite, oscEnable, cpuClkEnable, periphClkEnable, portDirHold;
    logic [7:0] stopCtrlData, stopCtrl;
    logic [1:0] divSelect, div;
    logic [15:0] resumePc, pc;
    sipd_pkg::sipd_cpu_req_s cpuReq;
    sipd_pkg::sipd_cpu_ans_s cpuAns;
    logic [16:0] expQ[$];
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 32'h824e;
    always #25 core_clk = ~core_clk;
    sipd_power_ctrl i_sipd_power_ctrl (.core_clk(core_clk), .rst(rst),
        .cpuReq(cpuReq), .stopCtrlWrite(stopCtrlWrite),
        .stopCtrlData(stopCtrlData), .divSelectWrite(divSelectWrite),
        .divSelectData(divSelectData), .stabCount(stabCount),
        .extIntPin(extIntPin), .extIntEnable(extIntEnable),
        .internalIrq(internalIrq), .oscEnable(oscEnable),
        .cpuClkEnable(cpuClkEnable), .periphClkEnable(periphClkEnable),
        .portDirHold(portDirHold), .divSelect(divSelect), .stopCtrl(stopCtrl),
        .resumePc(resumePc), .cpuAns(cpuAns));
    sipd_cpu_model i_sipd_cpu_model (.core_clk(core_clk),
        .cpuClkEnable(cpuClkEnable), .cpuReq(cpuReq),
        .stopCtrlWrite(stopCtrlWrite), .stopCtrlData(stopCtrlData));
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait for the cpu clock to come back
    task automatic waitCpu();
        for (int k = 0; k < 3000 && cpuClkEnable !== 1'b1; k++)
            @(posedge core_clk);
    endtask : waitCpu
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // each answer pulse takes the oldest note; none left is a mismatch
    task automatic chkAns(input logic [16:0] got);
        logic [16:0] note;
        if (expQ.size() != 0)
            note = expQ.pop_front();
        else
            note = ~got;
        chk(got, note);
    endtask : chkAns
    // every answer pulse is held against the queue
    always @(posedge core_clk)
    begin
        if (cpuAns.fetchStart === 1'b1)
            chkAns({1'b1, cpuAns.fetchAddr});
        else if (cpuAns.serviceIrq === 1'b1)
            chkAns({1'b0, resumePc});
    end
    // generous span: two reset waits plus a dozen short stop wakes
    initial
    begin
        #(20000 * 50);
        error_cnt++;
        test_done();
    end
    initial
    begin
        expQ.push_back({1'b1, 16'h0100});
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        waitCpu();
        chk({7'h0, divSelect, stopCtrl}, 17'h0);
        div = 2'($random(seed)) | 2'h1; // nonzero, unlike the reset value
        divSelectWrite <= 1'b1;
        divSelectData <= div;
        @(posedge core_clk);
        divSelectWrite <= 1'b0;
        $display("test reset done");
        i_sipd_cpu_model.put(8'h5A);
        i_sipd_cpu_model.run(8'h7F, 16'h0000, 1'b0);
        repeat (3) @(posedge core_clk);
        chk({16'h0, oscEnable}, 17'h1);
        $display("test refused stop done");
        for (int i = 0; i < 12; i++)
        begin
            pc = 16'($random(seed));
            expQ.push_back({1'b0, pc});
            i_sipd_cpu_model.run(8'h7F, pc, 1'b1);
            repeat (4) @(posedge core_clk);
            chk({16'h0, oscEnable}, 17'h0);
            chk({16'h0, cpuClkEnable}, 17'h0);
            // an internal source must not end a stop
            internalIrq <= 1'b1;
            repeat (2) @(posedge core_clk);
            chk({16'h0, oscEnable}, 17'h0);
            internalIrq <= 1'b0;
            extIntPin[i] <= 1'b1;
            waitCpu();
            chk({15'h0, divSelect}, {15'h0, div});
            chk({9'h0, stopCtrl}, 17'h0);
            chk({16'h0, periphClkEnable}, 17'h1);
            extIntPin[i] <= 1'b0;
            repeat (12) @(posedge core_clk);
        end
        $display("test stop wake done");
        pc = 16'($random(seed));
        expQ.push_back({1'b0, pc});
        i_sipd_cpu_model.run(8'h6F, pc, 1'b0);
        repeat (3) @(posedge core_clk);
        chk({16'h0, cpuClkEnable}, 17'h0);
        chk({16'h0, periphClkEnable}, 17'h1);
        chk({16'h0, portDirHold}, 17'h1);
        internalIrq <= 1'b1;
        waitCpu();
        internalIrq <= 1'b0;
        chk({15'h0, divSelect}, {15'h0, div});
        $display("test idle wake done");
        extIntEnable <= 12'h000;
        i_sipd_cpu_model.run(8'h6F, 16'h0000, 1'b0);
        repeat (50) @(posedge core_clk);
        chk({16'h0, cpuClkEnable}, 17'h0);
        expQ.push_back({1'b1, 16'h0100});
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        waitCpu();
        chk({7'h0, divSelect, stopCtrl}, 17'h0);
        $display("test masked idle done");
        repeat (4) @(posedge core_clk);
        chk({16'h0, expQ.size() == 0}, 17'h1);
        test_done();
    end
endmodule : sipd_power_ctrl_test
`default_nettype wire
